// >>> rtl/comm_fault_defs.svh
// Constants of the communication fault supervisor
// Functional notes
// [RQ1] Line fault counts as error only after outlasting the wait interval; interval resets to 0.
// [RQ2] Line recovering inside the interval raises no error; running continues.
// [RQ3] Inside the interval: keep running, normal indication, no fault output.
// [RQ4] Each line fault onset adds one to the fault counter.
// [RQ5] Counter runs 0..65535 and wraps to zero.
// [RQ6] Writing zero clears the counter; other values are refused.
// [RQ7] Counter copied to nonvolatile store hourly; reset reloads the copy.
// [RQ8] Stop mode accepts 0..3, zero after reset.
// [RQ9] After the interval: mode 0 coast+fault, 1 decel+fault, 2 decel+warning, 3 continue.
// [RQ10] Option fault: modes 0,3 coast with fault; modes 1,2 decel then fault.
// [RQ11] On clearing: modes 0,1 stay tripped, 2 restarts, 3 continues; option stays tripped.
// [RQ12] Line fault recorded as code A1, option circuit fault as code F1.
// [RQ13] Fault output drives alarm output and network fault bit together.
// [RQ14] History kept only with fault output; otherwise written temporarily.
// [RQ15] After non-latching fault clears, normal display and last fault shown.
// [RQ16] Ramps use ordinary decel and accel times.
// [RQ17] Mode 2 restart reuses run and speed commands from before the fault.
// [RQ18] Mode 2 line recovery during decel resumes acceleration at once.
// [RQ19] Line fault stops data traffic always; trips only in network operation.
// [RQ20] Connection fault trips in all modes, traffic continues.
// [RQ21] Selectable reactions apply under network operation.
// [RQ22] Line and option fault codes shown until the operator clears them.
// [RQ23] Wait timer counts tenth-second ticks, restarts per onset, clears on recovery.
`ifndef COMM_FAULT_DEFS_SVH
`define COMM_FAULT_DEFS_SVH
`define CLK_KHZ        40000
`define TICK_MS        100
`define TICK_CYC       (`TICK_MS * `CLK_KHZ)
`define HOUR_S         3600
`define HOUR_TICKS     (`HOUR_S * 1000 / `TICK_MS)
`define WAIT_MAX       14'h270E
`define WAIT_RST       14'h0000
`define MODE_RST       2'h0
`define CODE_LINE      8'hA1
`define CODE_OPT       8'hF1
`define CODE_NONE      8'h00
`endif

// >>> rtl/comm_fault_pkg.sv
// Types of the communication fault supervisor
`default_nettype none
package comm_fault_pkg;
	typedef enum logic [1:0] {OPM_PU = 2'h0, OPM_EXT = 2'h1, OPM_NET = 2'h2} op_mode_t;
	typedef enum logic [1:0] {DSP_NORMAL = 2'h0, DSP_LINE = 2'h1, DSP_OPT = 2'h2, DSP_WARN = 2'h3} disp_t;
	typedef enum logic [2:0] {
		ST_RUN   = 3'h0,
		ST_WAIT  = 3'h1,
		ST_COAST = 3'h2,
		ST_DECEL = 3'h3,
		ST_TRIP  = 3'h4,
		ST_WARN  = 3'h5,
		ST_PASS  = 3'h6
	} sup_st_t;
endpackage : comm_fault_pkg
`default_nettype wire

// >>> rtl/fault_wait_timer.sv
// Wait timer that measures a line fault in tenth-second ticks
`timescale 1ns/100ps
`default_nettype none
module fault_wait_timer
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Control
	input  wire logic        tick,
	input  wire logic        restart,
	input  wire logic        active,
	input  wire logic [13:0] interval,
	// Result
	output logic             expired
);
	logic [13:0] ticks_q;
	logic [13:0] ticks_d;

	// Restart on onset, clear on recovery, saturate at the top
	always_comb
	begin
		ticks_d = ticks_q;
		if (restart || !active)
			ticks_d = 14'h0000; // [RQ23]
		else if (tick && ticks_q != 14'h3FFF)
			ticks_d = ticks_q + 14'h0001; // [RQ23]
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			ticks_q <= 14'h0000;
		else
			ticks_q <= ticks_d;
	end

	// Expiry once the elapsed ticks reach the interval
	assign expired = active && !restart && (ticks_q >= interval); // [RQ1]
endmodule : fault_wait_timer
`default_nettype wire

// >>> rtl/fault_counter_store.sv
// Cumulative line fault counter with hourly nonvolatile copy
`timescale 1ns/100ps
`include "comm_fault_defs.svh"
`default_nettype none
module fault_counter_store
#(
	parameter int HOUR_TICKS = `HOUR_TICKS
)
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Events
	input  wire logic        tick,
	input  wire logic        onset,
	input  wire logic        wr,
	input  wire logic [15:0] wdata,
	// Nonvolatile store
	input  wire logic [15:0] nv_rd_data,
	output logic             nv_wr,
	output logic [15:0]      nv_wr_data,
	// Count
	output logic [15:0]      count
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [31:0] hour_q;
	logic [31:0] hour_d;
	logic        nvw_q;
	logic        nvw_d;
	logic        clr;

	assign clr = wr && (wdata == 16'h0000); // [RQ6]

	// Count onsets; an onset in the clearing cycle survives
	always_comb
	begin
		hour_d = hour_q;
		nvw_d  = 1'b0;
		if (clr)
			cnt_d = onset ? 16'h0001 : 16'h0000; // [RQ6]
		else
			cnt_d = cnt_q + {15'h0000, onset}; // [RQ4] [RQ5]
		if (tick)
		begin
			if (hour_q >= 32'(HOUR_TICKS - 1))
			begin
				hour_d = 32'h0000_0000;
				nvw_d  = 1'b1; // [RQ7]
			end
			else
				hour_d = hour_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt_q  <= nv_rd_data; // [RQ7]
			hour_q <= 32'h0000_0000;
			nvw_q  <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			hour_q <= hour_d;
			nvw_q  <= nvw_d;
		end
	end

	assign nv_wr      = nvw_q;
	assign nv_wr_data = cnt_q;
	assign count      = cnt_q;
endmodule : fault_counter_store
`default_nettype wire

// >>> rtl/comm_fault_supervisor.sv
// Supervisor that decides the drive reaction to fieldbus faults
`timescale 1ns/100ps
`include "comm_fault_defs.svh"
`default_nettype none
module comm_fault_supervisor
	import comm_fault_pkg::*;
#(
	parameter int TICK_CYC   = `TICK_CYC,
	parameter int HOUR_TICKS = `HOUR_TICKS
)
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Settings writes
	input  wire logic        wait_wr,
	input  wire logic [13:0] wait_wdata,
	input  wire logic        mode_wr,
	input  wire logic [1:0]  mode_wdata,
	input  wire logic        cnt_wr,
	input  wire logic [15:0] cnt_wdata,
	// Fault sources and drive state
	input  wire logic        line_fault,
	input  wire logic        opt_fault,
	input  wire logic        conn_fault,
	input  wire op_mode_t    op_mode,
	input  wire logic        stopped,
	input  wire logic        fault_clear,
	// Commands from the master
	input  wire logic        run_cmd,
	input  wire logic [15:0] speed_cmd,
	// Nonvolatile store
	input  wire logic [15:0] nv_rd_data,
	output logic             nv_wr,
	output logic [15:0]      nv_wr_data,
	// Settings read back
	output logic [13:0]      fault_wait_interval,
	output logic [15:0]      fault_event_counter,
	output logic [1:0]       fault_stop_mode,
	// Drive reaction
	output logic             coast_stop,
	output logic             decel_stop,
	output logic             run_out,
	output logic [15:0]      speed_out,
	output logic             comm_active,
	// Indication and alarms
	output disp_t            disp,
	output logic             alarm_relay_output,
	output logic             net_fault_bit,
	// Fault history
	output logic             hist_wr,
	output logic             hist_keep,
	output logic [7:0]       hist_code,
	output logic [7:0]       hist_last
);
	sup_st_t     st_q;
	sup_st_t     st_d;
	logic        src_opt_q;
	logic        src_opt_d;
	logic [13:0] wait_q;
	logic [13:0] wait_d;
	logic [1:0]  mode_q;
	logic [1:0]  mode_d;
	logic [31:0] pre_q;
	logic [31:0] pre_d;
	logic        tick;
	logic        line_q;
	logic        onset;
	logic        expired;
	logic        net;
	logic        opt_trip;
	logic        hwr_d;
	logic        hwr_q;
	logic        hkeep_d;
	logic        hkeep_q;
	logic [7:0]  hcode_d;
	logic [7:0]  hcode_q;
	logic [7:0]  hlast_d;
	logic [7:0]  hlast_q;
	logic        run_d;
	logic        run_q;
	logic [15:0] spd_d;
	logic [15:0] spd_q;
	logic        sav_run_d;
	logic        sav_run_q;
	logic [15:0] sav_spd_d;
	logic [15:0] sav_spd_q;
	logic        comm_d;
	logic        comm_q;

	// Stop style for an option fault by mode: coast for 0 and 3
	function automatic sup_st_t opt_reaction(input logic [1:0] m);
		opt_reaction = (m == 2'h0 || m == 2'h3) ? ST_COAST : ST_DECEL;
	endfunction : opt_reaction

	// True when the state carries the fault output
	function automatic logic fault_out(input sup_st_t s);
		fault_out = (s == ST_COAST) || (s == ST_TRIP);
	endfunction : fault_out

	assign net      = (op_mode == OPM_NET);
	assign onset    = line_fault && !line_q;
	// Connection fault trips everywhere, option circuit fault only under network
	assign opt_trip = conn_fault || (opt_fault && net); // [RQ20] [RQ19]

	// Tenth-second prescaler and settings
	always_comb
	begin
		pre_d  = pre_q + 32'h0000_0001;
		wait_d = wait_q;
		mode_d = mode_q;
		if (pre_q >= 32'(TICK_CYC - 1))
			pre_d = 32'h0000_0000;
		if (wait_wr && wait_wdata <= `WAIT_MAX)
			wait_d = wait_wdata; // [RQ1]
		if (mode_wr)
			mode_d = mode_wdata; // [RQ8]
	end
	assign tick = (pre_q >= 32'(TICK_CYC - 1)); // [RQ23]

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			pre_q  <= 32'h0000_0000;
			wait_q <= `WAIT_RST;
			mode_q <= `MODE_RST;
			line_q <= 1'b0;
		end
		else
		begin
			pre_q  <= pre_d;
			wait_q <= wait_d;
			mode_q <= mode_d;
			line_q <= line_fault;
		end
	end

	// Line fault wait timer
	fault_wait_timer u_wait
	(
		.mclk     (mclk),
		.rst_n    (rst_n),
		.tick     (tick),
		.restart  (onset),
		.active   (line_fault),
		.interval (wait_q),
		.expired  (expired)
	);

	// Cumulative fault counter
	fault_counter_store #(.HOUR_TICKS(HOUR_TICKS)) u_cnt
	(
		.mclk       (mclk),
		.rst_n      (rst_n),
		.tick       (tick),
		.onset      (onset),
		.wr         (cnt_wr),
		.wdata      (cnt_wdata),
		.nv_rd_data (nv_rd_data),
		.nv_wr      (nv_wr),
		.nv_wr_data (nv_wr_data),
		.count      (fault_event_counter)
	);

	// Reaction state machine
	always_comb
	begin
		st_d      = st_q;
		src_opt_d = src_opt_q;
		case (st_q)
			ST_RUN, ST_WAIT, ST_PASS:
			begin
				if (opt_trip)
				begin
					src_opt_d = 1'b1;
					st_d      = opt_reaction(mode_q); // [RQ10]
				end
				else if (st_q == ST_RUN)
				begin
					if (line_fault && net) // [RQ21] [RQ19]
						st_d = ST_WAIT; // [RQ3]
				end
				else if (!line_fault || !net)
					st_d = ST_RUN; // [RQ2] [RQ11]
				else if (st_q == ST_WAIT && expired)
				begin
					src_opt_d = 1'b0;
					case (mode_q) // [RQ9]
						2'h0:    st_d = ST_COAST;
						2'h3:    st_d = ST_PASS;
						default: st_d = ST_DECEL;
					endcase
				end
			end
			ST_COAST:
			begin
				if (stopped)
					st_d = ST_TRIP;
			end
			ST_DECEL:
			begin
				if (!src_opt_q && mode_q == 2'h2 && !line_fault)
					st_d = ST_RUN; // [RQ18]
				else if (stopped)
					st_d = (!src_opt_q && mode_q == 2'h2) ? ST_WARN : ST_TRIP; // [RQ9] [RQ10]
			end
			ST_TRIP:
			begin
				if (fault_clear && !line_fault && !opt_trip)
					st_d = ST_RUN; // [RQ22] [RQ11]
			end
			ST_WARN:
			begin
				if (!line_fault)
					st_d = ST_RUN; // [RQ11] [RQ15]
			end
			default:
				st_d = ST_RUN;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st_q      <= ST_RUN;
			src_opt_q <= 1'b0;
		end
		else
		begin
			st_q      <= st_d;
			src_opt_q <= src_opt_d;
		end
	end

	// Fault history, command hold and data traffic
	always_comb
	begin
		hwr_d     = 1'b0;
		hkeep_d   = hkeep_q;
		hcode_d   = hcode_q;
		hlast_d   = hlast_q;
		sav_run_d = sav_run_q;
		sav_spd_d = sav_spd_q;
		if (fault_out(st_d) && !fault_out(st_q))
		begin
			hwr_d   = 1'b1;
			hkeep_d = 1'b1; // [RQ14]
			hcode_d = src_opt_d ? `CODE_OPT : `CODE_LINE; // [RQ12]
			hlast_d = hcode_d;
		end
		else if (st_d == ST_WARN && st_q != ST_WARN)
		begin
			hwr_d   = 1'b1;
			hkeep_d = 1'b0; // [RQ14]
			hcode_d = `CODE_LINE; // [RQ12]
			hlast_d = `CODE_LINE; // [RQ15]
		end
		if (st_q == ST_RUN && !line_fault)
		begin
			sav_run_d = run_cmd; // [RQ17]
			sav_spd_d = speed_cmd;
		end
		// Saved commands drive the drive until it is back in ST_RUN with a clean line
		run_d = (st_q == ST_RUN && !line_fault) ? run_cmd : sav_run_q; // [RQ17]
		spd_d = (st_q == ST_RUN && !line_fault) ? speed_cmd : sav_spd_q;
		comm_d = !line_fault && !(opt_fault && !conn_fault); // [RQ19] [RQ20]
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			hwr_q     <= 1'b0;
			hkeep_q   <= 1'b0;
			hcode_q   <= `CODE_NONE;
			hlast_q   <= `CODE_NONE;
			run_q     <= 1'b0;
			spd_q     <= 16'h0000;
			sav_run_q <= 1'b0;
			sav_spd_q <= 16'h0000;
			comm_q    <= 1'b0;
		end
		else
		begin
			hwr_q     <= hwr_d;
			hkeep_q   <= hkeep_d;
			hcode_q   <= hcode_d;
			hlast_q   <= hlast_d;
			run_q     <= run_d;
			spd_q     <= spd_d;
			sav_run_q <= sav_run_d;
			sav_spd_q <= sav_spd_d;
			comm_q    <= comm_d;
		end
	end

	// Outputs; ramps use the drive's ordinary times
	assign coast_stop          = (st_q == ST_COAST) || (st_q == ST_TRIP);
	assign decel_stop          = (st_q == ST_DECEL) || (st_q == ST_WARN); // [RQ16]
	assign run_out             = run_q && (st_q == ST_RUN || st_q == ST_WAIT || st_q == ST_PASS); // [RQ3]
	assign speed_out           = spd_q;
	assign comm_active         = comm_q;
	assign alarm_relay_output  = fault_out(st_q); // [RQ13]
	assign net_fault_bit       = fault_out(st_q); // [RQ13]
	assign disp                = fault_out(st_q) ? (src_opt_q ? DSP_OPT : DSP_LINE) :
	                             (st_q == ST_WARN) ? DSP_WARN : DSP_NORMAL; // [RQ22] [RQ15]
	assign hist_wr             = hwr_q;
	assign hist_keep           = hkeep_q;
	assign hist_code           = hcode_q;
	assign hist_last           = hlast_q;
	assign fault_wait_interval = wait_q;
	assign fault_stop_mode     = mode_q;
endmodule : comm_fault_supervisor
`default_nettype wire

// >>> verif/comm_fault_props.sv
// Checker of the communication fault supervisor ports
`timescale 1ns/100ps
`default_nettype none
module comm_fault_props
	import comm_fault_pkg::*;
(
	// Clock, reset and settings writes
	input wire logic        mclk, rst_n, wait_wr, mode_wr, cnt_wr,
	input wire logic [13:0] wait_wdata,
	input wire logic [1:0]  mode_wdata,
	input wire logic [15:0] cnt_wdata,
	// Fault sources
	input wire logic        line_fault, opt_fault, conn_fault,
	input wire op_mode_t    op_mode,
	// Observed outputs
	input wire logic [13:0] fault_wait_interval,
	input wire logic [15:0] fault_event_counter,
	input wire logic [1:0]  fault_stop_mode,
	input wire logic        coast_stop, decel_stop, comm_active, alarm_relay_output,
	input wire logic        net_fault_bit, hist_wr, hist_keep, nv_wr,
	input wire disp_t       disp,
	input wire logic [7:0]  hist_code
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	reset_values_a: assert property ($rose(rst_n) |-> fault_wait_interval == 14'h0 && fault_stop_mode == 2'h0)
		else $error("settings not cleared by reset");
	wait_write_a: assert property (wait_wr |=> fault_wait_interval == ($past(wait_wdata) > 14'h270E ?
		$past(fault_wait_interval) : $past(wait_wdata))) else $error("wait interval write wrong");
	mode_write_a: assert property (mode_wr |=> fault_stop_mode == $past(mode_wdata))
		else $error("stop mode write wrong");
	count_step_a: assert property ($rose(line_fault) && !cnt_wr |=> fault_event_counter == $past(fault_event_counter) + 16'h1)
		else $error("fault counter step wrong");
	count_clear_a: assert property (cnt_wr && !$rose(line_fault) |=> fault_event_counter ==
		($past(cnt_wdata) == 16'h0 ? 16'h0 : $past(fault_event_counter))) else $error("counter write wrong");
	quiet_wait_a: assert property ($rose(line_fault) && op_mode == OPM_NET && fault_wait_interval >= 14'h2 &&
		!alarm_relay_output && !decel_stop && !opt_fault && !conn_fault
		|=> (!alarm_relay_output && !coast_stop && !decel_stop && disp == DSP_NORMAL)[*3]) else $error("reaction inside wait");
	comm_stop_a: assert property (line_fault |=> !comm_active)
		else $error("traffic kept on line fault");
	no_trip_a: assert property (line_fault && op_mode != OPM_NET && !opt_fault && !conn_fault && !alarm_relay_output
		|=> !alarm_relay_output) else $error("trip outside network operation");
	alarm_pair_a: assert property (alarm_relay_output == net_fault_bit)
		else $error("alarm and fault bit differ");
	conn_trip_a: assert property ($rose(conn_fault) && fault_stop_mode inside {2'h0, 2'h3} && !alarm_relay_output
		&& !decel_stop |-> ##[1:3] (alarm_relay_output && coast_stop)) else $error("connection fault no coast");
	keep_hist_a: assert property (hist_wr && hist_keep |-> alarm_relay_output)
		else $error("history kept without fault output");
	temp_hist_a: assert property (hist_wr && !hist_keep |-> disp == DSP_WARN && hist_code == 8'hA1)
		else $error("temporary history wrong");
	nv_pulse_a: assert property (nv_wr |=> !nv_wr)
		else $error("store pulse too long");

	// Main scenarios reached
	cover property (hist_wr && hist_keep);
	cover property (disp == DSP_WARN);
	cover property (nv_wr);
endmodule : comm_fault_props

bind comm_fault_supervisor comm_fault_props i_props (.mclk, .rst_n, .wait_wr, .mode_wr, .cnt_wr, .wait_wdata,
	.mode_wdata, .cnt_wdata, .line_fault, .opt_fault, .conn_fault, .op_mode, .fault_wait_interval,
	.fault_event_counter, .fault_stop_mode, .coast_stop, .decel_stop, .comm_active, .alarm_relay_output,
	.net_fault_bit, .hist_wr, .hist_keep, .nv_wr, .disp, .hist_code);
`default_nettype wire

// >>> verif/fieldbus_master_model.sv
// Model of the network master feeding commands over the line
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master_model
(
	// Clock and break request
	input  wire logic        mclk,
	input  wire logic        brk,
	// Line towards the drive
	output logic             line_fault,
	output logic             run_cmd,
	output logic [15:0]      speed_cmd
);
	// Idle line at time zero
	initial
	begin
		line_fault = 1'b0;
		run_cmd    = 1'b0;
		speed_cmd  = 16'h0;
	end

	// Healthy link sends fixed commands; a broken one reads as stop with a drifting speed
	always @(posedge mclk)
	begin
		line_fault <= brk;
		run_cmd    <= !brk;
		speed_cmd  <= brk ? speed_cmd + 16'h1111 : 16'h1234;
	end
endmodule : fieldbus_master_model
`default_nettype wire

// >>> verif/comm_fault_supervisor_tb.sv
// Bench of the communication fault supervisor
`timescale 1ns/100ps
`default_nettype none
module comm_fault_supervisor_tb
	import comm_fault_pkg::*;
;
	logic        mclk = 1'b0, rst_n = 1'b0, brk = 1'b0, stopped = 1'b0, fault_clear = 1'b0;
	logic        wait_wr = 1'b0, mode_wr = 1'b0, cnt_wr = 1'b0, opt_fault = 1'b0, conn_fault = 1'b0;
	logic [13:0] wait_wdata = 14'h0;
	logic [1:0]  mode_wdata = 2'h0;
	logic [15:0] cnt_wdata = 16'h0, nv_rd_data = 16'hFFFE;
	op_mode_t    op_mode = OPM_PU;
	wire logic   line_fault, run_cmd;
	wire logic [15:0] speed_cmd;
	logic        nv_wr, coast_stop, decel_stop, run_out, comm_active, alarm_relay_output;
	logic        net_fault_bit, hist_wr, hist_keep;
	logic [15:0] nv_wr_data, fault_event_counter, speed_out;
	logic [13:0] fault_wait_interval;
	logic [1:0]  fault_stop_mode;
	logic [7:0]  hist_code, hist_last;
	disp_t       disp;
	int          error_cnt = 0, checks_done = 0, tmo = 0;
	logic [3:0]  alarm_on = 4'b0011;
	disp_t       disp_on[4] = '{DSP_LINE, DSP_LINE, DSP_WARN, DSP_NORMAL};

	logic [3:0]  stop_sr = 4'h0;

	// Clock, and a motor that stands still a few cycles after any stop request
	initial forever #12.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		stop_sr <= (decel_stop || coast_stop) ? {stop_sr[2:0], 1'b1} : 4'h0;
		stopped <= (decel_stop || coast_stop) && stop_sr[3];
	end

	comm_fault_supervisor #(.TICK_CYC(4), .HOUR_TICKS(3)) i_dut (.mclk, .rst_n, .wait_wr, .wait_wdata, .mode_wr,
		.mode_wdata, .cnt_wr, .cnt_wdata, .line_fault, .opt_fault, .conn_fault, .op_mode, .stopped, .fault_clear,
		.run_cmd, .speed_cmd, .nv_rd_data, .nv_wr, .nv_wr_data, .fault_wait_interval, .fault_event_counter,
		.fault_stop_mode, .coast_stop, .decel_stop, .run_out, .speed_out, .comm_active, .disp, .alarm_relay_output,
		.net_fault_bit, .hist_wr, .hist_keep, .hist_code, .hist_last);
	fieldbus_master_model i_master (.mclk, .brk, .line_fault, .run_cmd, .speed_cmd);

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	// Settings write: 0 interval, 1 stop mode, 2 counter
	task automatic sw(input int k, input logic [15:0] d);
		@(posedge mclk);
		wait_wr    <= (k == 0);
		mode_wr    <= (k == 1);
		cnt_wr     <= (k == 2);
		wait_wdata <= d[13:0];
		mode_wdata <= d[1:0];
		cnt_wdata  <= d;
		@(posedge mclk);
		{wait_wr, mode_wr, cnt_wr} <= 3'h0;
		#1;
	endtask : sw

	task automatic brk_for(input logic v, input int n);
		@(posedge mclk);
		brk <= v;
		cyc(n);
	endtask : brk_for

	task automatic clr();
		@(posedge mclk);
		fault_clear <= 1'b1;
		@(posedge mclk);
		fault_clear <= 1'b0;
		cyc(5);
		chk("cleared", alarm_relay_output, 16'h0);
	endtask : clr

	task automatic rst();
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (11) @(posedge mclk);
		rst_n <= 1'b1;
		cyc(1);
	endtask : rst

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	// Hang guard
	always @(posedge mclk)
	begin
		tmo <= tmo + 1;
		if (tmo == 5000)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	// Test sequence
	initial
	begin
		rst();
		chk("interval", fault_wait_interval, 16'h0);
		chk("mode", fault_stop_mode, 16'h0);
		chk("count", fault_event_counter, 16'hFFFE);
		brk_for(1, 10);
		chk("count", fault_event_counter, 16'hFFFF);
		chk("comm", comm_active, 16'h0);
		chk("alarm", alarm_relay_output, 16'h0);
		sw(2, 16'h0005);
		chk("count", fault_event_counter, 16'hFFFF);
		brk_for(0, 5);
		brk_for(1, 5);
		chk("count", fault_event_counter, 16'h0000);
		brk_for(0, 5);
		brk_for(1, 5);
		sw(2, 16'h0000);
		chk("count", fault_event_counter, 16'h0000);
		brk_for(0, 5);
		sw(0, 16'd9999);
		chk("interval", fault_wait_interval, 16'h0);
		sw(0, 16'd9998);
		chk("interval", fault_wait_interval, 16'h270E);
		for (int m = 0; m < 4; m++)
		begin
			sw(1, 16'(m));
			chk("mode", fault_stop_mode, 16'(m));
		end
		sw(0, 16'h0);
		$display("test counter and settings done");
		@(posedge mclk);
		op_mode <= OPM_NET;
		for (int m = 0; m < 4; m++)
		begin
			sw(1, 16'(m));
			brk_for(1, 30);
			chk("alarm", alarm_relay_output, 16'(alarm_on[m]));
			chk("fault bit", net_fault_bit, 16'(alarm_on[m]));
			chk("disp", disp, disp_on[m]);
			chk("comm", comm_active, 16'h0);
			chk("run", run_out, 16'(m == 3));
			if (m >= 2)
				chk("speed", speed_out, 16'h1234);
			brk_for(0, 30);
			chk("held", alarm_relay_output, 16'(alarm_on[m]));
			chk("disp", disp, (m < 2) ? DSP_LINE : DSP_NORMAL);
			chk("run", run_out, 16'(m >= 2));
			chk("hist", hist_last, 16'hA1);
			if (m >= 2)
				chk("speed", speed_out, 16'h1234);
			clr();
		end
		sw(1, 16'h2);
		brk_for(1, 3);
		chk("decel", decel_stop, 16'h1);
		brk_for(0, 4);
		chk("decel", decel_stop, 16'h0);
		chk("run", run_out, 16'h1);
		$display("test stop modes done");
		sw(1, 16'h0);
		sw(0, 16'd30);
		brk_for(1, 40);
		chk("alarm", alarm_relay_output, 16'h0);
		chk("disp", disp, DSP_NORMAL);
		brk_for(0, 10);
		chk("alarm", alarm_relay_output, 16'h0);
		brk_for(1, 100);
		chk("alarm", alarm_relay_output, 16'h0);
		cyc(40);
		chk("alarm", alarm_relay_output, 16'h1);
		brk_for(0, 5);
		clr();
		sw(0, 16'h0);
		$display("test wait interval done");
		sw(1, 16'h1);
		@(posedge mclk);
		opt_fault <= 1'b1;
		cyc(1);
		chk("decel", decel_stop, 16'h1);
		chk("alarm", alarm_relay_output, 16'h0);
		cyc(9);
		chk("alarm", alarm_relay_output, 16'h1);
		chk("disp", disp, DSP_OPT);
		chk("hist", hist_last, 16'hF1);
		@(posedge mclk);
		opt_fault <= 1'b0;
		cyc(10);
		chk("held", alarm_relay_output, 16'h1);
		clr();
		sw(1, 16'h3);
		@(posedge mclk);
		op_mode    <= OPM_EXT;
		conn_fault <= 1'b1;
		cyc(1);
		chk("coast", coast_stop, 16'h1);
		cyc(29);
		chk("alarm", alarm_relay_output, 16'h1);
		chk("comm", comm_active, 16'h1);
		chk("hist", hist_last, 16'hF1);
		@(posedge mclk);
		conn_fault <= 1'b0;
		clr();
		$display("test option faults done");
		for (int i = 0; i < 40 && !nv_wr; i++)
			cyc(1);
		chk("nv_wr", nv_wr, 16'h1);
		chk("nv data", nv_wr_data, 16'h0007);
		@(posedge mclk);
		nv_rd_data <= 16'h0042;
		rst();
		chk("count", fault_event_counter, 16'h0042);
		chk("mode", fault_stop_mode, 16'h0);
		$display("test store and reset done");
		print_verdict();
	end
endmodule : comm_fault_supervisor_tb
`default_nettype wire
